//--- design/thermometer_thermostat_core.sv
// temperature conversion, three-wire serial port and thermostat outputs
`timescale 1ns/1ps
`default_nettype none
`include "thermo_core_map.svh"
module thermometer_thermostat_core #(
  parameter int COUNT_W = 9,
  parameter logic [8:0] BASE_COUNT = 9'h0c8,
  parameter logic [8:0] SLOPE_INIT = 9'h040,
  parameter logic [8:0] SLOPE_STEP = 9'h001,
  parameter int CONVERT_STROBE_MAX_CYC = `CONVERT_STROBE_MAX_MS * 1000000 / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clock_or_convert_in,
  input wire logic xferEnableIn,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  input wire logic gateIn,
  input wire logic refOscIn,
  input wire logic cpuMode,
  input wire logic [8:0] nvUpperIn,
  input wire logic [8:0] nvLowerIn,
  output logic nvWrite,
  output logic nvWriteUpper,
  output logic [8:0] nvWriteData,
  output logic over_limit_out,
  output logic under_limit_out,
  output logic hysteresis_out,
  output logic convBusy
);

  localparam int TIMER_W = $clog2(CONVERT_STROBE_MAX_CYC + 1);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(CONVERT_STROBE_MAX_CYC - 1);

  // pin synchronisers, three stages
  logic [4:0] pinIn;
  logic [4:0] syncA_ff;
  logic [4:0] syncB_ff;
  logic [4:0] syncC_ff;
  logic [4:0] pinLvl_ff;
  logic [4:0] agree;
  logic [4:0] pinRise;
  logic [4:0] pinFall;

  assign pinIn = {dataIn, xferEnableIn, shift_clock_or_convert_in, gateIn, refOscIn};
  assign agree = ~(syncB_ff ^ syncC_ff);
  assign pinRise = agree & syncC_ff & ~pinLvl_ff;
  assign pinFall = agree & ~syncC_ff & pinLvl_ff;

  // synchroniser chain, reset to idle pin levels so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_ff <= `PIN_RST;
      syncB_ff <= `PIN_RST;
      syncC_ff <= `PIN_RST;
    end else begin
      syncA_ff <= pinIn;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  // settled level once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinLvl_ff <= `PIN_RST; // serial clock idles high
    end else begin
      pinLvl_ff <= (agree & syncC_ff) | (~agree & pinLvl_ff);
    end
  end

  logic xferOn;
  logic sclkRise;
  logic sclkFall;
  assign xferOn = pinLvl_ff[`PIN_XFER];
  assign sclkRise = pinRise[`PIN_SCLK];
  assign sclkFall = pinFall[`PIN_SCLK];

  // conversion datapath
  thermo_core_pkg::convert_strobe_state_t convState_ff;
  logic [COUNT_W-1:0] downCnt_ff;
  logic [COUNT_W-1:0] slopeAcc_ff;
  logic [COUNT_W-1:0] countReg_ff;
  logic [8:0] tempAcc_ff;
  logic [8:0] tempResult_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic convDone_ff;
  logic cmdConvert_ff;
  logic slopeLoad_ff;
  logic standaloneLow;
  logic startConv;

  // convert pin held low while port idle and not in host mode
  assign standaloneLow = !cpuMode && !xferOn && !pinLvl_ff[`PIN_SCLK];
  assign startConv = cmdConvert_ff || standaloneLow;

  // gated down-counter with slope reload
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      convState_ff <= thermo_core_pkg::CONVERT_STROBE_IDLE;
      downCnt_ff <= '0;
      slopeAcc_ff <= '0;
      countReg_ff <= '0;
      tempAcc_ff <= `TEMP_MIN;
      tempResult_ff <= `TEMP_MIN;
      timer_ff <= '0;
      convDone_ff <= 1'b0;
    end else begin
      convDone_ff <= 1'b0;
      case (convState_ff)
        thermo_core_pkg::CONVERT_STROBE_IDLE: begin
          if (startConv) begin
            downCnt_ff <= COUNT_W'(BASE_COUNT);
            tempAcc_ff <= `TEMP_MIN;
            slopeAcc_ff <= COUNT_W'(SLOPE_INIT);
            timer_ff <= '0;
            convState_ff <= thermo_core_pkg::CONVERT_STROBE_ARM;
          end
        end
        thermo_core_pkg::CONVERT_STROBE_ARM: begin
          timer_ff <= timer_ff + 1'b1;
          if (timer_ff == TIMER_LAST) begin
            convState_ff <= thermo_core_pkg::CONVERT_STROBE_FINISH;
          end else if (pinRise[`PIN_GATE]) begin
            convState_ff <= thermo_core_pkg::CONVERT_STROBE_COUNT;
          end
        end
        thermo_core_pkg::CONVERT_STROBE_COUNT: begin
          timer_ff <= timer_ff + 1'b1;
          if (!pinLvl_ff[`PIN_GATE] || timer_ff == TIMER_LAST) begin
            convState_ff <= thermo_core_pkg::CONVERT_STROBE_FINISH;
          end else if (pinRise[`PIN_REF]) begin
            if (downCnt_ff <= COUNT_W'(1)) begin
              if (tempAcc_ff != `TEMP_MAX) begin
                tempAcc_ff <= tempAcc_ff + 9'h001;
              end
              downCnt_ff <= slopeAcc_ff;
              slopeAcc_ff <= slopeAcc_ff + COUNT_W'(SLOPE_STEP);
            end else begin
              downCnt_ff <= downCnt_ff - 1'b1;
            end
          end
        end
        thermo_core_pkg::CONVERT_STROBE_FINISH: begin
          tempResult_ff <= tempAcc_ff;
          countReg_ff <= downCnt_ff;
          convDone_ff <= 1'b1;
          convState_ff <= thermo_core_pkg::CONVERT_STROBE_IDLE;
        end
        default: begin
          convState_ff <= thermo_core_pkg::CONVERT_STROBE_IDLE;
        end
      endcase
      if (slopeLoad_ff) begin
        countReg_ff <= slopeAcc_ff;
      end
    end
  end

  // busy flag straight from a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      convBusy <= 1'b0;
    end else begin
      convBusy <= (convState_ff != thermo_core_pkg::CONVERT_STROBE_IDLE) || startConv;
    end
  end

  // thresholds and write strobes
  logic [8:0] upperThreshold_ff;
  logic [8:0] lowerThreshold_ff;
  logic nvLoadPend_ff;
  logic wrUpper_ff;
  logic wrLower_ff;
  logic [8:0] shiftIn_ff;

  // thresholds come from the nonvolatile store after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvLoadPend_ff <= 1'b1;
      upperThreshold_ff <= `THRESH_RST;
      lowerThreshold_ff <= `THRESH_RST;
    end else begin
      nvLoadPend_ff <= 1'b0;
      if (nvLoadPend_ff) begin
        upperThreshold_ff <= nvUpperIn;
        lowerThreshold_ff <= nvLowerIn;
      end else begin
        if (wrUpper_ff) begin
          upperThreshold_ff <= shiftIn_ff;
        end
        if (wrLower_ff) begin
          lowerThreshold_ff <= shiftIn_ff;
        end
      end
    end
  end

  // write-back request to the nonvolatile store
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvWrite <= 1'b0;
      nvWriteUpper <= 1'b0;
      nvWriteData <= 9'h000;
    end else begin
      nvWrite <= wrUpper_ff || wrLower_ff;
      if (wrUpper_ff || wrLower_ff) begin
        nvWriteUpper <= wrUpper_ff;
        nvWriteData <= shiftIn_ff;
      end
    end
  end

  // thermostat outputs, all from one completed reading
  thermo_core_pkg::thermo_t thermo_ff;
  logic signed [8:0] tempS;
  logic signed [8:0] upperS;
  logic signed [8:0] lowerS;
  assign tempS = tempAcc_ff;
  assign upperS = upperThreshold_ff;
  assign lowerS = lowerThreshold_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thermo_ff <= '0;
    end else if (convState_ff == thermo_core_pkg::CONVERT_STROBE_FINISH) begin
      thermo_ff.over <= (tempS >= upperS);
      thermo_ff.under <= (tempS <= lowerS);
      if (tempS >= upperS) begin
        thermo_ff.hyst <= 1'b1;
      end else if (tempS <= lowerS) begin
        thermo_ff.hyst <= 1'b0;
      end
    end
  end

  assign over_limit_out = thermo_ff.over;
  assign under_limit_out = thermo_ff.under;
  assign hysteresis_out = thermo_ff.hyst;

  // serial port
  thermo_core_pkg::ser_phase_t phase_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] cmdSh_ff;
  logic [8:0] shiftOut_ff;
  logic [7:0] cmdNext;
  logic [8:0] readValue;
  logic cmdIsRead;
  assign cmdNext = {pinLvl_ff[`PIN_DQ], cmdSh_ff[7:1]};

  // value selected by the incoming command
  always_comb begin
    readValue = 9'h000;
    cmdIsRead = 1'b1;
    case (cmdNext)
      `CMD_RD_TEMP: readValue = tempResult_ff;
      `CMD_RD_CNT: readValue = 9'(countReg_ff);
      `CMD_RD_SLOPE: readValue = 9'(slopeAcc_ff);
      `CMD_RD_TH: readValue = upperThreshold_ff;
      `CMD_RD_TL: readValue = lowerThreshold_ff;
      default: cmdIsRead = 1'b0;
    endcase
  end

  // shift engine, cleared whenever transfer enable drops
  always_ff @(posedge clk) begin
    if (!rst_n || !xferOn) begin
      phase_ff <= thermo_core_pkg::SER_CMD;
      bitCnt_ff <= 4'h0;
      cmdSh_ff <= 8'h00;
      shiftOut_ff <= 9'h000;
      shiftIn_ff <= 9'h000;
      dataOut <= 1'b0;
      dataOe <= 1'b0;
      cmdConvert_ff <= 1'b0;
      slopeLoad_ff <= 1'b0;
      wrUpper_ff <= 1'b0;
      wrLower_ff <= 1'b0;
    end else begin
      cmdConvert_ff <= 1'b0;
      slopeLoad_ff <= 1'b0;
      wrUpper_ff <= 1'b0;
      wrLower_ff <= 1'b0;
      if (sclkRise) begin
        case (phase_ff)
          thermo_core_pkg::SER_CMD: begin
            cmdSh_ff <= cmdNext;
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (bitCnt_ff == `CMD_LAST_BIT) begin
              bitCnt_ff <= 4'h0;
              if (cmdIsRead) begin
                shiftOut_ff <= readValue;
                slopeLoad_ff <= (cmdNext == `CMD_RD_SLOPE);
                phase_ff <= thermo_core_pkg::SER_RDATA;
              end else if (cmdNext == `CMD_WR_TH || cmdNext == `CMD_WR_TL) begin
                phase_ff <= thermo_core_pkg::SER_WDATA;
              end else begin
                cmdConvert_ff <= (cmdNext == `CMD_CONVERT);
                phase_ff <= thermo_core_pkg::SER_SKIP;
              end
            end
          end
          thermo_core_pkg::SER_WDATA: begin
            shiftIn_ff <= {pinLvl_ff[`PIN_DQ], shiftIn_ff[8:1]};
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (bitCnt_ff == `DATA_LAST_BIT) begin
              wrUpper_ff <= (cmdSh_ff == `CMD_WR_TH);
              wrLower_ff <= (cmdSh_ff == `CMD_WR_TL);
              phase_ff <= thermo_core_pkg::SER_SKIP;
            end
          end
          thermo_core_pkg::SER_RDATA: begin
            dataOe <= 1'b0; // released while clock high
          end
          default: begin
            phase_ff <= thermo_core_pkg::SER_SKIP;
          end
        endcase
      end else if (sclkFall && phase_ff == thermo_core_pkg::SER_RDATA) begin
        dataOut <= shiftOut_ff[0];
        shiftOut_ff <= {1'b0, shiftOut_ff[8:1]};
        dataOe <= 1'b1;
      end
    end
  end

endmodule : thermometer_thermostat_core
`default_nettype wire

//--- design/thermo_core_map.svh
// register-free constants for the thermometer/thermostat core
// Contract
// - Temperature result is 9-bit two's complement, LSB half a degree.
// - Readings span minus 55 to plus 125 degrees in half-degree steps.
// - Codes: +25 is 0x032, -0.5 is 0x1ff, -55 is 0x192.
// - Serial data moves least significant bit first both ways.
// - Value moves as one 9-bit word or two bytes, upper 7 bits zero.
// - After the MSB the data line carries zeros for further clocks.
// - Conversion start preloads counter with base count and register with -55.
// - Counter at zero inside gate: increment register, reload from slope, continue.
// - Slope accumulator changes counts needed per degree as temperature rises.
// - Read-counter returns the count left when the gate ended.
// - Read-slope loads slope into count register and returns it.
// - A conversion finishes within one second.
// - Stand-alone: falling clock/convert pin starts a conversion.
// - Over-limit output high while temperature at or above upper threshold.
// - Under-limit output high while temperature at or below lower threshold.
// - Hysteresis output set above upper, held until below lower threshold; the core sets it at or above upper and clears it at or below lower.
// - Thresholds live in nonvolatile storage and apply without a host.
// - Transfer-enable high opens a transfer; low ends it, data line released.
// - Inputs sampled on rising clock, outputs launched on falling clock.
// - Commands 0xaa temperature, 0xa0 counter, 0xa9 slope, nine data clocks.
// - Limit outputs stay active until temperature crosses back past threshold.
`ifndef THERMO_CORE_MAP_SVH
`define THERMO_CORE_MAP_SVH
`define TEMP_W 9
`define TEMP_MIN 9'h192
`define TEMP_MAX 9'h0fa
`define THRESH_RST 9'h000
`define CMD_RD_TEMP 8'haa
`define CMD_RD_CNT 8'ha0
`define CMD_RD_SLOPE 8'ha9
`define CMD_RD_TH 8'ha1
`define CMD_RD_TL 8'ha2
`define CMD_WR_TH 8'h01
`define CMD_WR_TL 8'h02
`define CMD_CONVERT 8'hee
`define CMD_LAST_BIT 4'h7
`define DATA_LAST_BIT 4'h8
`define CLK_PERIOD_NS 40
`define CONVERT_STROBE_MAX_MS 1000
`define PIN_DQ 4
`define PIN_XFER 3
`define PIN_SCLK 2
`define PIN_GATE 1
`define PIN_REF 0
`define PIN_RST 5'h04
`endif

//--- design/thermo_core_pkg.sv
// types shared by the thermometer/thermostat core
`default_nettype none
package thermo_core_pkg;
  typedef enum logic [1:0] {
    CONVERT_STROBE_IDLE = 2'b00,
    CONVERT_STROBE_ARM = 2'b01,
    CONVERT_STROBE_COUNT = 2'b11,
    CONVERT_STROBE_FINISH = 2'b10
  } convert_strobe_state_t;
  typedef enum logic [1:0] {
    SER_CMD = 2'b00,
    SER_WDATA = 2'b01,
    SER_RDATA = 2'b11,
    SER_SKIP = 2'b10
  } ser_phase_t;
  typedef struct packed {
    logic over;
    logic under;
    logic hyst;
  } thermo_t;
endpackage : thermo_core_pkg
`default_nettype wire

//--- sim/thermo_core_props.sv
// port assertions for the thermometer/thermostat core
`timescale 1ns/1ps
`default_nettype none
module thermo_core_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clock_or_convert_in,
  input wire logic xferEnableIn,
  input wire logic cpuMode,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic nvWrite,
  input wire logic over_limit_out,
  input wire logic under_limit_out,
  input wire logic hysteresis_out,
  input wire logic convBusy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // serial port drive rules
  a_oe_idle_off: assert property (!xferEnableIn [*6] |-> !dataOe)
    else $error("data line driven with transfer closed");
  a_oe_needs_xfer: assert property ($rose(dataOe) |-> xferEnableIn)
    else $error("data line driven outside a transfer");
  a_oe_release: assert property (dataOe && $rose(shift_clock_or_convert_in)
    |-> ##[1:6] !dataOe)
    else $error("data line not released after rising clock");
  a_dout_steady: assert property ((shift_clock_or_convert_in && xferEnableIn) [*5]
    |-> $stable(dataOut))
    else $error("data out moved while serial clock high");
  // conversion, thermostat and store write rules
  a_pin_start: assert property ($fell(shift_clock_or_convert_in)
    && !cpuMode && !xferEnableIn && !convBusy |-> ##[1:6] convBusy)
    else $error("pin fall did not start a conversion");
  a_hyst_set: assert property ($rose(hysteresis_out) |-> over_limit_out)
    else $error("hysteresis set without over limit");
  a_hyst_clear: assert property ($fell(hysteresis_out) |-> under_limit_out)
    else $error("hysteresis cleared without under limit");
  a_thermo_sync: assert property (!$stable({over_limit_out, under_limit_out, hysteresis_out})
    |-> $past(convBusy) || $past(convBusy, 2))
    else $error("thermostat changed outside a conversion end");
  a_nvw_pulse: assert property (nvWrite |=> !nvWrite)
    else $error("store write longer than one cycle");
  // main scenarios reached
  c_convert_strobe_done: cover property ($fell(convBusy));
  c_hyst_up: cover property ($rose(hysteresis_out));
  c_nv_write: cover property (nvWrite);
  c_read_out: cover property ($rose(dataOe));
endmodule : thermo_core_props
bind thermometer_thermostat_core thermo_core_props u_props (
  .clk(clk), .rst_n(rst_n), .shift_clock_or_convert_in(shift_clock_or_convert_in),
  .xferEnableIn(xferEnableIn), .cpuMode(cpuMode), .dataOut(dataOut), .dataOe(dataOe),
  .nvWrite(nvWrite), .over_limit_out(over_limit_out), .under_limit_out(under_limit_out),
  .hysteresis_out(hysteresis_out), .convBusy(convBusy));
`default_nettype wire

//--- sim/thermo_host_model.sv
// host controller on the three-wire serial link
`timescale 1ns/1ps
`default_nettype none
module thermo_host_model (
  input wire logic clk,
  input wire logic dataOut,
  input wire logic dataOe,
  output logic sclk,
  output logic xferEn,
  output logic dataIn
);
  logic drive = 1'b0;
  logic bitVal = 1'b0;
  logic junk = 1'b0;
  // released line wanders so stale data never passes
  always @(negedge clk) junk <= ~junk;
  assign dataIn = drive ? bitVal : (dataOe ? dataOut : junk);
  // link clock idles high between frames
  initial begin
    sclk = 1'b1;
    xferEn = 1'b0;
  end
  // one frame: command then nb data clocks, written or sampled
  task automatic frame(input logic [7:0] cmd, input logic [8:0] wd, input logic wr,
                       input int nb, output logic [10:0] rd);
    rd = '0;
    @(negedge clk) xferEn = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8 + nb; i++) begin
      sclk = 1'b0;
      drive = (i < 8) || wr;
      bitVal = (i < 8) ? cmd[i] : wd[i - 8];
      repeat (4) @(negedge clk);
      if (i >= 8) rd[i - 8] = dataIn;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    drive = 1'b0;
    xferEn = 1'b0;
    repeat (6) @(negedge clk);
  endtask : frame
endmodule : thermo_host_model
`default_nettype wire

//--- sim/thermometer_thermostat_core_bench.sv
// self-checking bench for the thermometer/thermostat core
`timescale 1ns/1ps
`default_nettype none
`include "thermo_core_map.svh"
module thermometer_thermostat_core_bench;
  localparam logic [8:0] BASE = 9'h0c8;
  localparam logic [8:0] SLOPE = 9'h040;
  logic clk, rst_n, gateIn, refOscIn, cpuMode, pinLow, sclk, xferEn, dataIn;
  logic dataOut, dataOe, nvWrite, nvWriteUpper, convBusy, hystExp, pin;
  logic [8:0] nvUpper = 9'h0fa;
  logic [8:0] nvLower = 9'h1ce;
  logic [8:0] nvWriteData, tempExp;
  logic [10:0] rd;
  thermo_core_pkg::thermo_t therm, thExp;
  logic [8:0] thTab [5] = '{9'h0fa, 9'h192, 9'h193, 9'h193, 9'h193};
  logic [8:0] tlTab [5] = '{9'h1ce, 9'h191, 9'h191, 9'h192, 9'h192};
  int nTab [5] = '{0, 0, 0, 0, 210};
  int n_errors = 0;
  int tests_run = 0;
  int seed = 79;
  int nRef;
  assign pin = pinLow ? 1'b0 : sclk;
  thermometer_thermostat_core #(.BASE_COUNT(BASE), .SLOPE_INIT(SLOPE), .CONVERT_STROBE_MAX_CYC(4000)) u_dut (
    .clk(clk), .rst_n(rst_n), .shift_clock_or_convert_in(pin), .xferEnableIn(xferEn),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .gateIn(gateIn), .refOscIn(refOscIn),
    .cpuMode(cpuMode), .nvUpperIn(nvUpper), .nvLowerIn(nvLower), .nvWrite(nvWrite),
    .nvWriteUpper(nvWriteUpper), .nvWriteData(nvWriteData), .over_limit_out(therm.over),
    .under_limit_out(therm.under), .hysteresis_out(therm.hyst), .convBusy(convBusy));
  thermo_host_model u_host (.clk(clk), .dataOut(dataOut), .dataOe(dataOe), .sclk(sclk),
    .xferEn(xferEn), .dataIn(dataIn));
  // nonvolatile threshold store outside the core
  always @(posedge clk) begin
    if (nvWrite && nvWriteUpper) nvUpper <= nvWriteData;
    if (nvWrite && !nvWriteUpper) nvLower <= nvWriteData;
  end
  // system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // expected thermostat levels from reading, thresholds and held hysteresis
  function automatic thermo_core_pkg::thermo_t therm_exp(input logic [8:0] t, hi, lo,
                                                         input logic h);
    therm_exp.over = $signed(t) >= $signed(hi);
    therm_exp.under = $signed(t) <= $signed(lo);
    therm_exp.hyst = therm_exp.over ? 1'b1 : (therm_exp.under ? 1'b0 : h);
  endfunction : therm_exp
  task automatic fail(input logic [8:0] exp, input logic [8:0] got);
    n_errors++;
    $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
  endtask : fail
  task automatic chk_word(input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) fail(exp, got);
  endtask : chk_word
  task automatic chk_therm(input thermo_core_pkg::thermo_t exp,
                           input thermo_core_pkg::thermo_t got);
    tests_run++;
    if (got !== exp) fail({6'h00, exp}, {6'h00, got});
  endtask : chk_therm
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // bounded wait for the busy level
  task automatic wait_busy(input logic lvl);
    int i;
    i = 0;
    while (convBusy !== lvl && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (convBusy !== lvl) begin
      fail({8'h00, lvl}, {8'h00, convBusy});
      complete_run();
    end
  endtask : wait_busy
  // read eleven clocks: nine data bits then trailing zeros
  task automatic rd_word(input logic [7:0] cmd, input logic [8:0] exp);
    u_host.frame(cmd, 9'h000, 1'b0, 11, rd);
    chk_word(exp, rd[8:0]);
    chk_word(9'h000, {7'h00, rd[10:9]});
  endtask : rd_word
  // one conversion, by command or by pin, with n reference counts in the gate
  task automatic convert(input int n, input logic alone);
    if (alone) begin
      pinLow = 1'b1;
      repeat (8) @(negedge clk);
      pinLow = 1'b0;
    end else begin
      u_host.frame(`CMD_CONVERT, 9'h000, 1'b0, 0, rd);
    end
    wait_busy(1'b1);
    gateIn = 1'b1;
    repeat (4) @(negedge clk);
    repeat (n) begin
      refOscIn = 1'b1;
      repeat (4) @(negedge clk);
      refOscIn = 1'b0;
      repeat (4) @(negedge clk);
    end
    gateIn = 1'b0;
    wait_busy(1'b0);
  endtask : convert
  // main sequence
  initial begin
    rst_n = 1'b0;
    {gateIn, refOscIn, pinLow, hystExp} = 4'h0;
    cpuMode = 1'b1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    rd_word(`CMD_RD_TEMP, `TEMP_MIN);
    rd_word(`CMD_RD_TH, 9'h0fa);
    rd_word(`CMD_RD_TL, 9'h1ce);
    for (int k = 0; k < 5; k++) begin
      u_host.frame(`CMD_WR_TH, thTab[k], 1'b1, 9, rd);
      u_host.frame(`CMD_WR_TL, tlTab[k], 1'b1, 9, rd);
      chk_word(thTab[k], nvUpper);
      chk_word(tlTab[k], nvLower);
      rd_word(`CMD_RD_TH, thTab[k]);
      rd_word(`CMD_RD_TL, tlTab[k]);
      nRef = (nTab[k] != 0) ? nTab[k] : 1 + ($unsigned($random(seed)) % 150);
      cpuMode = (k != 1);
      convert(nRef, k == 1);
      cpuMode = 1'b1;
      tempExp = (nRef >= 200) ? `TEMP_MIN + 9'h001 : `TEMP_MIN;
      rd_word(`CMD_RD_TEMP, tempExp);
      if (nRef < 199) begin
        rd_word(`CMD_RD_CNT, BASE - nRef[8:0]);
        rd_word(`CMD_RD_SLOPE, SLOPE);
        rd_word(`CMD_RD_CNT, SLOPE);
      end
      thExp = therm_exp(tempExp, thTab[k], tlTab[k], hystExp);
      chk_therm(thExp, therm);
      hystExp = thExp.hyst;
      $display("step %0d done", k);
    end
    complete_run();
  end
endmodule : thermometer_thermostat_core_bench
`default_nettype wire
